/* hw/reset_wake_sequencer.sv */
/*
 reset, start-up, watchdog and suspend sequencer of the hub controller.
 assumes firmware I/O strobes on the core clock, supply-good and bus
 activity from pins, and a core that obeys the reset and run controls.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - either reset restores defaults, clears stacks
// - status bit 4 supply, bit 6 timeout
// - fetch restarts at zero, nothing pushed
// - semi-suspend keeps CPU halted, clocks running
// - supply good starts start-up timer
// - 1 ms guard, then 95 ms wait
// - bus reset ends wait, interrupt pending
// - supply loss restarts whole sequence
// - any write to 0x26 clears watchdog
// - uncleared watchdog rolls over into reset
// - timeout loads 010X0001, holds 2 ms (loads 01000001 here, supply flag bit 4 cleared)
// - timeout clears USB device addresses
// - suspend stops clocks and timers
// - only GPIO irq or bus activity wakes
// - wake after 1 ms oscillator settle
// - resume at next instruction, then interrupts
module reset_wake_sequencer #(
    parameter int GUARD_CYC = rst_seq_pkg::GUARD_CYC,
    parameter int SEMI_CYC = rst_seq_pkg::SEMI_CYC,
    parameter int HOLD_CYC = rst_seq_pkg::TIMEOUT_HOLD_CYC,
    parameter int WAKE_CYC = rst_seq_pkg::WAKE_CYC,
    parameter int WATCH_CYC = rst_seq_pkg::WATCH_CYC
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // supply and bus pins
    input wire logic supply_good_i,
    input wire logic usb_bus_reset_i,
    input wire logic usb_bus_active_i,
    input wire logic gpio_wake_irq_i,
    // firmware I/O port
    input wire rst_seq_pkg::io_req_t io_req_i,
    output logic [7:0] io_rdata_o,
    // core controls
    output var rst_seq_pkg::core_ctl_t core_ctl_o,
    output logic [7:0] call_stack_pointer_o,
    output logic [7:0] data_stack_pointer_o,
    output logic [13:0] pc_load_o,
    output logic usb_addr_clear_o,
    output logic irq_disable_o,
    output logic bus_reset_pending_o
);
    ////////////////////////////////////////////////////////////////////////////
    logic supply_s;
    logic bus_rst_s;
    logic bus_act_s;
    sync3 u_sync_supply (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(supply_good_i),
        .level_o(supply_s)
    );
    sync3 u_sync_busrst (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(usb_bus_reset_i),
        .level_o(bus_rst_s)
    );
    sync3 u_sync_busact (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .pin_i(usb_bus_active_i),
        .level_o(bus_act_s)
    );
    ////////////////////////////////////////////////////////////////////////////
    typedef enum logic [2:0] {
        ST_SUPPLY_LOW,
        ST_GUARD,
        ST_SEMI,
        ST_RUN,
        ST_TIMEOUT_HOLD,
        ST_SUSPEND,
        ST_WAKE
    } seq_state_t;
    seq_state_t st_q;
    seq_state_t st_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic [31:0] wd_q;
    logic [31:0] wd_d;
    logic [7:0] stat_q;
    logic [7:0] stat_d;
    logic pend_q;
    logic pend_d;
    logic restart_q;
    logic restart_d;
    logic wr_stat;
    logic wr_wdog;
    logic wd_roll;
    assign wr_stat = io_req_i.wr && (io_req_i.addr == rst_seq_pkg::STATUS_CTRL_ADDR);
    assign wr_wdog = io_req_i.wr && (io_req_i.addr == rst_seq_pkg::WDOG_CLEAR_ADDR);
    assign wd_roll = (st_q == ST_RUN) && (wd_q >= 32'(WATCH_CYC - 1));
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q + 32'h1;
        wd_d = wd_q;
        stat_d = stat_q;
        pend_d = pend_q;
        restart_d = 1'b0;
        case (st_q)
            ST_SUPPLY_LOW:
            begin
                cnt_d = 32'h0;
                stat_d = rst_seq_pkg::STATUS_SUPPLY_RESET;
                pend_d = 1'b0;
                if (supply_s)
                    st_d = ST_GUARD;
            end
            ST_GUARD:
            begin
                if (cnt_q >= 32'(GUARD_CYC - 1))
                begin
                    st_d = ST_SEMI;
                    cnt_d = 32'h0;
                end
            end
            ST_SEMI:
            begin
                if (bus_rst_s || (cnt_q >= 32'(SEMI_CYC - 1)))
                begin
                    st_d = ST_RUN;
                    pend_d = bus_rst_s;
                    restart_d = 1'b1;
                    wd_d = 32'h0;
                end
            end
            ST_RUN:
            begin
                wd_d = wr_wdog ? 32'h0 : wd_q + 32'h1;
                if (wr_stat)
                begin
                    stat_d[rst_seq_pkg::RUN_BIT] = io_req_i.wdata[rst_seq_pkg::RUN_BIT];
                    stat_d[rst_seq_pkg::SUSPEND_BIT] = io_req_i.wdata[rst_seq_pkg::SUSPEND_BIT];
                    if (io_req_i.wdata[rst_seq_pkg::SUSPEND_BIT])
                        st_d = ST_SUSPEND;
                end
                if (wd_roll)
                begin
                    st_d = ST_TIMEOUT_HOLD;
                    cnt_d = 32'h0;
                    stat_d = rst_seq_pkg::STATUS_TIMEOUT_RESET;
                    pend_d = 1'b0;
                end
            end
            ST_TIMEOUT_HOLD:
            begin
                if (cnt_q >= 32'(HOLD_CYC - 1))
                begin
                    st_d = ST_RUN;
                    restart_d = 1'b1;
                    wd_d = 32'h0;
                end
            end
            ST_SUSPEND:
            begin
                cnt_d = 32'h0;
                if (gpio_wake_irq_i || bus_act_s)
                    st_d = ST_WAKE;
            end
            ST_WAKE:
            begin
                if (cnt_q >= 32'(WAKE_CYC - 1))
                begin
                    st_d = ST_RUN;
                    stat_d[rst_seq_pkg::SUSPEND_BIT] = 1'b0;
                    wd_d = 32'h0;
                end
            end
            default:
                st_d = ST_SUPPLY_LOW;
        endcase
        if (!supply_s)
        begin
            st_d = ST_SUPPLY_LOW;
            restart_d = 1'b0;
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_q <= ST_SUPPLY_LOW;
            cnt_q <= 32'h0;
            wd_q <= 32'h0;
            stat_q <= rst_seq_pkg::STATUS_SUPPLY_RESET;
            pend_q <= 1'b0;
            restart_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            wd_q <= wd_d;
            stat_q <= stat_d;
            pend_q <= pend_d;
            restart_q <= restart_d;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    always_comb
    begin
        rdata_d = 8'h00;
        if (io_req_i.rd && (io_req_i.addr == rst_seq_pkg::STATUS_CTRL_ADDR))
            rdata_d = stat_q;
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            rdata_q <= 8'h00;
        else
            rdata_q <= rdata_d;
    end
    logic in_reset;
    assign in_reset = (st_q == ST_SUPPLY_LOW) || (st_q == ST_GUARD) || (st_q == ST_SEMI)
        || (st_q == ST_TIMEOUT_HOLD);
    assign io_rdata_o = rdata_q;
    assign core_ctl_o.cpu_run = (st_q == ST_RUN);
    assign core_ctl_o.core_reset = in_reset;
    assign core_ctl_o.clk_on = (st_q != ST_SUSPEND) && (st_q != ST_SUPPLY_LOW);
    assign core_ctl_o.fetch_restart = restart_q;
    assign call_stack_pointer_o = rst_seq_pkg::STACK_RESET;
    assign data_stack_pointer_o = rst_seq_pkg::STACK_RESET;
    assign pc_load_o = rst_seq_pkg::RESET_VECTOR;
    assign usb_addr_clear_o = in_reset;
    assign irq_disable_o = in_reset;
    assign bus_reset_pending_o = pend_q;
    ////////////////////////////////////////////////////////////////////////////
    a_timeout_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_TIMEOUT_HOLD) |-> stat_q == 8'h41)
        else $error("timeout status pattern wrong");
    a_supply_flag: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_GUARD) |-> stat_q[4] && !stat_q[6])
        else $error("supply flag not set");
    a_supply_loss: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !supply_s |=> st_q == ST_SUPPLY_LOW)
        else $error("supply loss ignored");
    a_guard_nobus: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_GUARD && supply_s && cnt_q < 32'(GUARD_CYC - 1)) |=> st_q == ST_GUARD)
        else $error("guard interval interrupted");
    a_bus_abort: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SEMI && bus_rst_s && supply_s)
        |=> st_q == ST_RUN && pend_q && core_ctl_o.fetch_restart)
        else $error("bus reset did not abort wait");
    a_wdog_roll: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (wd_roll && supply_s) |=> st_q == ST_TIMEOUT_HOLD && usb_addr_clear_o)
        else $error("watchdog rollover missed");
    a_wdog_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_RUN && wr_wdog && !wd_roll && supply_s && !wr_stat) |=> wd_q == 32'h0)
        else $error("watchdog not cleared");
    a_suspend_stop: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SUSPEND) |-> !core_ctl_o.clk_on && !core_ctl_o.cpu_run)
        else $error("clock running in suspend");
    a_suspend_wake: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SUSPEND && !gpio_wake_irq_i && !bus_act_s && supply_s)
        |=> st_q == ST_SUSPEND)
        else $error("spurious wake");
    a_semi_halt: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SEMI) |-> core_ctl_o.clk_on && !core_ctl_o.cpu_run)
        else $error("cpu running in semi-suspend");
    a_guard_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SUPPLY_LOW && supply_s) |=> st_q == ST_GUARD && cnt_q == 32'h0)
        else $error("start-up timer not started");
    a_semi_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SEMI && !bus_rst_s && supply_s && cnt_q < 32'(SEMI_CYC - 1))
        |=> st_q == ST_SEMI)
        else $error("semi-suspend ended early");
    a_semi_end: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SEMI && supply_s && cnt_q >= 32'(SEMI_CYC - 1))
        |=> st_q == ST_RUN && core_ctl_o.fetch_restart)
        else $error("semi-suspend did not end");
    a_hold_length: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_TIMEOUT_HOLD && supply_s && cnt_q < 32'(HOLD_CYC - 1))
        |=> st_q == ST_TIMEOUT_HOLD)
        else $error("timeout reset released early");
    a_hold_end: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_TIMEOUT_HOLD && supply_s && cnt_q >= 32'(HOLD_CYC - 1))
        |=> core_ctl_o.cpu_run && core_ctl_o.fetch_restart)
        else $error("timeout reset not released");
    a_wake_settle: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_WAKE && supply_s && cnt_q < 32'(WAKE_CYC - 1))
        |=> st_q == ST_WAKE && core_ctl_o.clk_on && !core_ctl_o.cpu_run)
        else $error("wake settle too short");
    a_wake_resume: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_WAKE && supply_s && cnt_q >= 32'(WAKE_CYC - 1))
        |=> core_ctl_o.cpu_run && !stat_q[rst_seq_pkg::SUSPEND_BIT])
        else $error("wake did not resume");
    a_wake_norefetch: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_WAKE) |=> !core_ctl_o.fetch_restart)
        else $error("fetch restarted after wake");
    a_suspend_enter: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_RUN && wr_stat && io_req_i.wdata[rst_seq_pkg::SUSPEND_BIT] && !wd_roll
        && supply_s) |=> st_q == ST_SUSPEND && stat_q[rst_seq_pkg::SUSPEND_BIT])
        else $error("suspend write ignored");
    a_wdog_frozen: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SUSPEND) |=> wd_q == $past(wd_q))
        else $error("watchdog ran in suspend");
    a_wdog_count: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_RUN && !wr_wdog) |=> wd_q == $past(wd_q) + 32'h1)
        else $error("watchdog not counting");
    a_read_status: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (io_req_i.rd && io_req_i.addr == rst_seq_pkg::STATUS_CTRL_ADDR)
        |=> io_rdata_o == $past(stat_q))
        else $error("status read wrong");
    a_read_other: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (io_req_i.rd && io_req_i.addr != rst_seq_pkg::STATUS_CTRL_ADDR) |=> io_rdata_o == 8'h00)
        else $error("write-only location read back");
    a_supply_reload: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_SUPPLY_LOW)
        |=> stat_q == rst_seq_pkg::STATUS_SUPPLY_RESET && !bus_reset_pending_o)
        else $error("supply reset did not reload status");
    a_timeout_load: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        wd_roll |=> stat_q == rst_seq_pkg::STATUS_TIMEOUT_RESET && !bus_reset_pending_o)
        else $error("timeout did not load status");
    a_status_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (st_q == ST_RUN && wr_stat && !wd_roll) |=> stat_q[7:4] == $past(stat_q[7:4])
        && stat_q[rst_seq_pkg::RUN_BIT] == $past(io_req_i.wdata[rst_seq_pkg::RUN_BIT]))
        else $error("status write touched read-only bits");
    a_restart_pulse: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        core_ctl_o.fetch_restart |-> core_ctl_o.cpu_run ##1 !core_ctl_o.fetch_restart)
        else $error("fetch restart not a single pulse in run");
    a_reset_outputs: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        core_ctl_o.core_reset |-> usb_addr_clear_o && irq_disable_o && !core_ctl_o.cpu_run)
        else $error("reset outputs inconsistent");
    c_bus_abort: cover property (@(posedge core_clk_i) st_q == ST_SEMI ##1 pend_q);
    c_timeout: cover property (@(posedge core_clk_i) st_q == ST_TIMEOUT_HOLD ##1 st_q == ST_RUN);
    c_wake: cover property (@(posedge core_clk_i) st_q == ST_WAKE ##1 st_q == ST_RUN);
    c_startup: cover property (@(posedge core_clk_i) st_q == ST_SEMI ##1 st_q == ST_RUN);
    c_supply_loss: cover property (@(posedge core_clk_i) st_q == ST_RUN ##1 st_q == ST_SUPPLY_LOW);
endmodule
`default_nettype wire

/* hw/sync3.sv */
/*
 three-stage input synchroniser with agreement filter.
 assumes an asynchronous pin input and a single core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module sync3 (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // pin and result
    input wire logic pin_i,
    output logic level_o
);
    logic [2:0] sh_q;
    logic [2:0] sh_d;
    logic lvl_q;
    logic lvl_d;
    always_comb
    begin
        sh_d = {sh_q[1:0], pin_i};
        lvl_d = (sh_q[2] == sh_q[1]) ? sh_q[2] : lvl_q;
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            sh_q <= 3'h0;
            lvl_q <= 1'b0;
        end
        else
        begin
            sh_q <= sh_d;
            lvl_q <= lvl_d;
        end
    end
    assign level_o = lvl_q;
endmodule
`default_nettype wire

/* inc/rst_seq_pkg.sv */
/*
 reset and wake sequencer package: register offsets, status bit positions,
 reset values and timing constants.
 assumes a 200 MHz core clock and an 8-bit I/O-mapped firmware port.
*/
`default_nettype none
package rst_seq_pkg;
    localparam logic [7:0] WDOG_CLEAR_ADDR = 8'h26;
    localparam logic [7:0] STATUS_CTRL_ADDR = 8'hff;
    localparam int RUN_BIT = 0;
    localparam int SUSPEND_BIT = 3;
    localparam int SUPPLY_FLAG_BIT = 4;
    localparam int TIMEOUT_FLAG_BIT = 6;
    localparam logic [7:0] STATUS_SUPPLY_RESET = 8'h11;
    localparam logic [7:0] STATUS_TIMEOUT_RESET = 8'h41;
    localparam logic [7:0] STATUS_WRITE_MASK = 8'h09;
    localparam logic [7:0] STACK_RESET = 8'h00;
    localparam logic [13:0] RESET_VECTOR = 14'h0000;
    localparam int CLK_MHZ = 200;
    localparam int GUARD_US = 1000;
    localparam int SEMI_US = 95000;
    localparam int TIMEOUT_HOLD_US = 2000;
    localparam int WAKE_US = 1000;
    localparam int WATCH_US = 8000;
    localparam int GUARD_CYC = GUARD_US * CLK_MHZ;
    localparam int SEMI_CYC = SEMI_US * CLK_MHZ;
    localparam int TIMEOUT_HOLD_CYC = TIMEOUT_HOLD_US * CLK_MHZ;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int WATCH_CYC = WATCH_US * CLK_MHZ;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } io_req_t;
    typedef struct packed {
        logic cpu_run;
        logic core_reset;
        logic clk_on;
        logic fetch_restart;
    } core_ctl_t;
endpackage
`default_nettype wire

/* verification/fw_partner.sv */
/*
 firmware and upstream host model: i/o strobes of the core, supply and bus pins.
 assumes the sequencer's i/o contract on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fw_partner (
    // clock
    input wire logic core_clk_i,
    // firmware port
    output var rst_seq_pkg::io_req_t io_req_o,
    input wire logic [7:0] io_rdata_i,
    // pins
    output var logic supply_good_o,
    output var logic usb_bus_reset_o,
    output var logic usb_bus_active_o,
    output var logic gpio_wake_irq_o
);
    initial
    begin
        io_req_o = '0;
        {supply_good_o, usb_bus_reset_o, usb_bus_active_o, gpio_wake_irq_o} = 4'h8;
    end
    ////////////////////////////////////////////////////////////////////////////
    // handler traffic is plain i/o, never a return
    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        io_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk_i);
        #1;
        io_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk_i);
        #1;
        io_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge core_clk_i);
        #1;
        d = io_rdata_i;
        io_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
    endtask
    task automatic enter_suspend();
        io_wr(rst_seq_pkg::STATUS_CTRL_ADDR, 8'h09);
    endtask
    task automatic set_pins(input logic [3:0] p);
        @(posedge core_clk_i);
        #1;
        {supply_good_o, usb_bus_reset_o, usb_bus_active_o, gpio_wake_irq_o} = p;
    endtask
    // timeout flag counts only without the supply flag
    function automatic logic timeout_cause(input logic [7:0] s);
        return s[6] & ~s[4];
    endfunction
endmodule
`default_nettype wire

/* verification/tb_top.sv */
/*
 testbench of the reset and wake sequencer with the firmware partner.
 assumes shortened timing parameters and a 200 MHz core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    localparam int GD = 10;
    localparam int SM = 50;
    localparam int HD = 20;
    localparam int WK = 10;
    localparam int WT = 40;
    logic core_clk_i;
    logic rst_n_i;
    logic sup, brst, bact, gpio, aclr, idis, pend, f, bad;
    rst_seq_pkg::io_req_t req;
    rst_seq_pkg::core_ctl_t ctl;
    logic [7:0] rdata, csp, dsp, s;
    logic [13:0] pcl;
    int fail_count;
    int total_checks;
    int n;
    ////////////////////////////////////////////////////////////////////////////
    reset_wake_sequencer #(.GUARD_CYC(GD), .SEMI_CYC(SM), .HOLD_CYC(HD), .WAKE_CYC(WK),
        .WATCH_CYC(WT)) i_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .supply_good_i(sup), .usb_bus_reset_i(brst), .usb_bus_active_i(bact),
        .gpio_wake_irq_i(gpio), .io_req_i(req), .io_rdata_o(rdata), .core_ctl_o(ctl),
        .call_stack_pointer_o(csp), .data_stack_pointer_o(dsp), .pc_load_o(pcl),
        .usb_addr_clear_o(aclr), .irq_disable_o(idis), .bus_reset_pending_o(pend));
    fw_partner i_fw (.core_clk_i(core_clk_i), .io_req_o(req), .io_rdata_i(rdata),
        .supply_good_o(sup), .usb_bus_reset_o(brst), .usb_bus_active_o(bact),
        .gpio_wake_irq_o(gpio));
    initial
    begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic check_rng(input string nm, input int v, input int lo, input int hi);
        check(nm, 16'(v >= lo && v <= hi), 16'h0001);
    endtask
    function automatic logic cond(input int sel);
        case (sel)
            0: return ctl.cpu_run;
            1: return ctl.core_reset;
            default: return ~ctl.core_reset;
        endcase
    endfunction
    task automatic wait_on(input int sel, input int lim, output int cnt);
        cnt = 0;
        while (cond(sel) !== 1'b1)
        begin
            @(posedge core_clk_i);
            #1;
            cnt++;
            if (cnt > lim)
            begin
                check("wait limit", 16'h0000, 16'h0001);
                test_done();
            end
        end
    endtask
    task automatic seen_restart(output logic r);
        r = 1'b0;
        repeat (3)
        begin
            r = r | ctl.fetch_restart;
            @(posedge core_clk_i);
            #1;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        fail_count = 0;
        total_checks = 0;
        bad = 1'b0;
        rst_n_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1 rst_n_i = 1'b1;
        repeat (GD + 8) @(posedge core_clk_i);
        #1;
        check("cpu_run semi", ctl.cpu_run, 16'h0);
        check("clk_on semi", ctl.clk_on, 16'h1);
        check("reset clears", {aclr, idis}, 16'h3);
        check("stack ptrs", {csp, dsp}, 16'h0000);
        check("pc_load", pcl, 16'h0000);
        wait_on(0, SM + 20, n);
        check_rng("startup delay", n + GD + 8, GD + SM, GD + SM + 10);
        seen_restart(f);
        check("fetch restart", f, 16'h1);
        i_fw.io_rd(8'hff, s);
        check("status supply", s, 16'h11);
        check("cause supply", i_fw.timeout_cause(s), 16'h0);
        i_fw.io_rd(8'h26, s);
        check("wdog clear reads", s, 16'h0000);
        for (int k = 0; k < 120; k++)
        begin
            if (k % 30 == 0)
                i_fw.io_wr(8'h26, 8'(k + 3));
            else
                @(posedge core_clk_i);
            #1;
            bad = bad | ctl.core_reset;
        end
        check("kept alive", bad, 16'h0);
        i_fw.io_wr(8'h26, 8'hc3);
        wait_on(1, WT + 10, n);
        check_rng("watch window", n, WT - 4, WT + 3);
        check("addr clear", aclr, 16'h1);
        wait_on(2, HD + 10, n);
        check_rng("hold length", n, HD - 2, HD + 2);
        seen_restart(f);
        check("fetch restart", f, 16'h1);
        i_fw.io_rd(8'hff, s);
        check("status timeout", s, 16'h41);
        check("cause timeout", i_fw.timeout_cause(s), 16'h1);
        for (int w = 0; w < 2; w++)
        begin
            i_fw.io_wr(8'h26, 8'h00);
            i_fw.enter_suspend();
            repeat (2) @(posedge core_clk_i);
            #1;
            check("clk_on sleep", {ctl.clk_on, ctl.cpu_run}, 16'h0);
            repeat (WT + 20) @(posedge core_clk_i);
            #1;
            check("asleep", {ctl.cpu_run, ctl.core_reset}, 16'h0);
            i_fw.set_pins(w == 0 ? 4'h9 : 4'ha);
            wait_on(0, WK + 12, n);
            check_rng("wake delay", n, WK, WK + 8);
            seen_restart(f);
            check("no refetch", f, 16'h0);
            i_fw.set_pins(4'h8);
            i_fw.io_rd(8'hff, s);
            check("status awake", s, 16'h41);
        end
        i_fw.set_pins(4'h0);
        repeat (6) @(posedge core_clk_i);
        #1;
        check("supply lost", ctl.core_reset, 16'h1);
        i_fw.set_pins(4'hc);
        wait_on(0, GD + 20, n);
        check_rng("bus reset cut", n, GD, GD + 10);
        check("pending", pend, 16'h1);
        i_fw.set_pins(4'h8);
        i_fw.io_rd(8'hff, s);
        check("status again", s, 16'h11);
        test_done();
    end
endmodule
`default_nettype wire
